//--- hw/flash_pin_ctrl.sv
// host-bus pin control of the flash die: strobes, address capture, burst, wait and write protect
`timescale 1ns/1ps
// Overview of operation
// R1: address and data word are captured on the rising edge of write strobe.
// R2: synchronous mode uses the bus clock to advance the burst address.
// R3: sync read captures address on address-valid rise or first clock edge while low.
// R4: async mode latches on address-valid rise, flows through while it is low.
// R5: data-ready asserted level comes from wait_polarity_bit, config bit 10.
// R6: data-ready driven only while chip select and output enable are low.
// R7: sync burst reads assert data-ready while data invalid; host samples when deasserted.
// R8: data-ready stays deasserted in async page reads and all writes.
// R9: write protect low enforces lock-down; unlock of locked-down block refused.
// R10: write protect high disables lock-down, unlocks may release such blocks.
// R11: RAM output enable, write strobe and byte enables are ignored.
// R12: chip select high deselects die, standby, data and data-ready float.
// R13: data drivers enabled only while output enable is low.
// R14: leaving reset enters async read-array; reset low disables all operation.
// R15: address-valid, bus clock and write strobe ignored while chip select high.
module flash_pin_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic write_n,
  input wire logic address_valid_n,
  input wire logic bus_clk,
  input wire logic write_protect_n,
  input wire logic [flash_pin_pkg::ADDR_W-1:0] addr,
  input wire logic [flash_pin_pkg::DATA_W-1:0] dq_in,
  input wire logic ram_out_en_n,
  input wire logic ram_write_n,
  input wire logic ram_upper_byte_n,
  input wire logic ram_lower_byte_n,
  input wire logic [flash_pin_pkg::CFG_W-1:0] read_config_reg,
  input wire logic sync_mode_sel,
  input wire logic array_data_valid,
  input wire logic [flash_pin_pkg::DATA_W-1:0] array_rd_data,
  input wire logic unlock_req,
  input wire logic block_locked_down,
  output logic [flash_pin_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic wait_out,
  output logic wait_oe,
  output logic [flash_pin_pkg::ADDR_W-1:0] array_addr,
  output logic addr_captured,
  output logic [flash_pin_pkg::ADDR_W-1:0] wr_addr,
  output logic [flash_pin_pkg::DATA_W-1:0] wr_data,
  output logic wr_strobe,
  output logic unlock_grant,
  output logic lockdown_on,
  output logic die_active,
  output logic sync_mode
);
  import flash_pin_pkg::*;

  ////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin synchroniser; the ram pins are deliberately not sampled
  pin_bus_if pins ();
  assign pins.raw = {dq_in, addr, write_protect_n, bus_clk, address_valid_n, write_n, out_en_n, chip_sel_n}; // [R11]

  pin_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pins(pins)
  );

  // field selection from the synchronised bundle
  wire cs_n_s = pins.synced[P_CS];
  wire oe_n_s = pins.synced[P_OE];
  wire we_n_s = pins.synced[P_WE];
  wire adv_n_s = pins.synced[P_ADV];
  wire bclk_s = pins.synced[P_BCLK];
  wire wp_n_s = pins.synced[P_WP];
  wire [ADDR_W-1:0] addr_s = pins.synced[PIN_CTRL_W +: ADDR_W];
  wire [DATA_W-1:0] data_s = pins.synced[PIN_CTRL_W + ADDR_W +: DATA_W];

  ////////////////////////////////////////////////////////////////
  // previous values for edge detection
  logic we_n_prev_q;
  logic adv_n_prev_q;
  logic bclk_prev_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      we_n_prev_q <= 1'b1;
      adv_n_prev_q <= 1'b1;
      bclk_prev_q <= 1'b0;
    end else begin
      we_n_prev_q <= we_n_s;
      adv_n_prev_q <= adv_n_s;
      bclk_prev_q <= bclk_s;
    end
  end

  // strobe events, all but the address-valid fall gated by chip select
  wire selected = !cs_n_s; // [R12]
  wire we_rise = selected && we_n_s && !we_n_prev_q; // [R1] [R15]
  wire adv_rise = selected && adv_n_s && !adv_n_prev_q; // [R15]
  wire adv_fall = !adv_n_s && adv_n_prev_q;
  wire bclk_rise = selected && bclk_s && !bclk_prev_q; // [R15]
  wire reading = selected && !oe_n_s && we_n_s;

  ////////////////////////////////////////////////////////////////
  // bus phase tracking
  phase_e phase_q;
  phase_e phase_d;
  logic held_q;
  logic mode_q;
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] offset_q;

  // sync capture: first of address-valid rise or clock edge while low
  wire sync_cap = mode_q && !held_q && (adv_rise || (bclk_rise && !adv_n_s)); // [R3]
  wire async_cap = !mode_q && adv_rise; // [R4]
  wire capture = sync_cap || async_cap;
  // burst advances only on clock edges once the address is held
  wire advance = mode_q && held_q && adv_n_s && bclk_rise && reading; // [R2]

  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      PH_IDLE: begin
        if (selected && !adv_n_s) begin
          phase_d = PH_ADDR;
        end else if (selected && !we_n_s) begin
          phase_d = PH_WRITE;
        end
      end
      PH_ADDR: begin
        if (!selected) begin
          phase_d = PH_IDLE;
        end else if (capture || held_q) begin
          phase_d = PH_BURST;
        end
      end
      PH_BURST: begin
        if (!selected) begin
          phase_d = PH_IDLE;
        end else if (!we_n_s) begin
          phase_d = PH_WRITE;
        end else if (adv_fall) begin
          phase_d = PH_ADDR;
        end
      end
      PH_WRITE: begin
        if (!selected || we_rise) begin
          phase_d = PH_IDLE;
        end
      end
    endcase
  end

  // flow-through address while address-valid is low in async mode
  wire flow = !mode_q && selected && !adv_n_s; // [R4]
  wire [ADDR_W-1:0] addr_d = flow ? addr_s : (base_q + offset_q);

  ////////////////////////////////////////////////////////////////
  // mode, capture and burst state; reset leaves async read-array
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PH_IDLE;
      mode_q <= 1'b0; // [R14]
      held_q <= 1'b0;
      base_q <= ADDR_RST;
      offset_q <= ADDR_RST;
    end else begin
      phase_q <= phase_d;
      mode_q <= sync_mode_sel;
      // capture wins over a same-cycle valid fall, else the clock recaptures
      if (capture) begin
        held_q <= 1'b1;
      end else if (adv_fall || !selected) begin
        held_q <= 1'b0;
      end
      if (capture) begin
        base_q <= addr_s; // [R3] [R4]
        offset_q <= ADDR_RST;
      end else if (advance) begin
        offset_q <= offset_q + BURST_STEP; // [R2]
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // write capture on the strobe rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_addr <= ADDR_RST;
      wr_data <= DATA_RST;
      wr_strobe <= 1'b0;
    end else begin
      wr_strobe <= we_rise; // [R1]
      if (we_rise) begin
        wr_addr <= addr_s; // [R1]
        wr_data <= data_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // data-ready and data drivers
  wire wt_pol = read_config_reg[WAIT_POL_BIT]; // [R5]
  // busy only for sync reads; async page and writes keep it deasserted
  wire busy = mode_q && reading && (phase_q != PH_WRITE) && !array_data_valid; // [R7] [R8]
  wire wait_lvl = wt_pol ? busy : !busy; // [R5]
  wire drive = selected && !oe_n_s; // [R6] [R12] [R13]

  // write-protect gates lock-down on unlock requests
  wire lock_on = !wp_n_s; // [R9] [R10]
  wire grant = unlock_req && (!block_locked_down || !lock_on); // [R9] [R10]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_out <= DATA_RST;
      dq_oe <= 1'b0;
      wait_out <= 1'b0;
      wait_oe <= 1'b0;
      array_addr <= ADDR_RST;
      addr_captured <= 1'b0;
      unlock_grant <= 1'b0;
      lockdown_on <= 1'b1;
      die_active <= 1'b0; // [R14]
      sync_mode <= 1'b0;
    end else begin
      dq_out <= array_rd_data;
      dq_oe <= drive && we_n_s; // [R13]
      wait_out <= wait_lvl;
      wait_oe <= drive; // [R6]
      array_addr <= addr_d;
      addr_captured <= capture;
      unlock_grant <= grant;
      lockdown_on <= lock_on;
      die_active <= selected; // [R12]
      sync_mode <= mode_q;
    end
  end
endmodule // flash_pin_ctrl

//--- hw/flash_pin_pkg.sv
// shared constants and types for the flash host-bus pin control
package flash_pin_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int CFG_W = 16;
  localparam int WAIT_POL_BIT = 10;
  localparam int PIN_CTRL_W = 6;
  localparam int PIN_W = PIN_CTRL_W + ADDR_W + DATA_W;
  // positions of the control pins in the synchronised bundle
  localparam int P_CS = 0;
  localparam int P_OE = 1;
  localparam int P_WE = 2;
  localparam int P_ADV = 3;
  localparam int P_BCLK = 4;
  localparam int P_WP = 5;
  localparam logic [ADDR_W-1:0] ADDR_RST = 23'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] BURST_STEP = 23'h000001;
  // idle pin levels: selects, strobes and protect high, bus clock low
  localparam logic [PIN_W-1:0] PIN_RST = 45'h00000000002F;
  // bus phase, gray coded along idle -> address -> burst -> write
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_BURST = 2'b11,
    PH_WRITE = 2'b10
  } phase_e;
endpackage

//--- hw/pin_bus_if.sv
// synchronised host pins passed from the synchroniser to the controller
`timescale 1ns/1ps
interface pin_bus_if;
  import flash_pin_pkg::*;
  logic [PIN_W-1:0] raw;
  logic [PIN_W-1:0] synced;
  modport sync_side (input raw, output synced);
  modport ctrl_side (output raw, input synced);
endinterface

//--- hw/pin_sync.sv
// two-stage synchroniser bank for all host pins but the ram pins
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  pin_bus_if.sync_side pins
);
  import flash_pin_pkg::*;

  ////////////////////////////////////////////////////////////////
  // one pair of flops per pin; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < PIN_W; i++) begin : g_bit
      logic meta_q;
      logic stable_q;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= PIN_RST[i];
          stable_q <= PIN_RST[i];
        end else begin
          meta_q <= pins.raw[i];
          stable_q <= meta_q;
        end
      end
      assign pins.synced[i] = stable_q;
    end
  endgenerate
endmodule // pin_sync

//--- bench/flash_pin_monitor.sv
// assertion checker bound to the flash pin control ports
`timescale 1ns/1ps
module flash_pin_monitor (
  input logic clk,
  input logic resetn,
  input logic chip_sel_n,
  input logic out_en_n,
  input logic write_n,
  input logic write_protect_n,
  input logic sync_mode_sel,
  input logic array_data_valid,
  input logic unlock_req,
  input logic block_locked_down,
  input logic [flash_pin_pkg::CFG_W-1:0] read_config_reg,
  input logic [flash_pin_pkg::DATA_W-1:0] wr_data,
  input logic wait_out,
  input logic wait_oe,
  input logic dq_oe,
  input logic addr_captured,
  input logic wr_strobe,
  input logic unlock_grant,
  input logic die_active
);
  import flash_pin_pkg::*;
  // pins lag about three clocks, so causes must stand eight
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  //////////////////////////////
  desel_quiet_a: assert property (chip_sel_n[*8] |-> !(wr_strobe | addr_captured | die_active | wait_oe))
    else $error("activity while deselected");
  oe_float_a: assert property (out_en_n[*8] |-> !dq_oe && !wait_oe)
    else $error("driver on while output enable high");
  unlock_refuse_a: assert property ((!write_protect_n)[*8] ##0 (unlock_req && block_locked_down) |=> !unlock_grant)
    else $error("unlock granted under lock-down");
  unlock_free_a: assert property (write_protect_n[*8] ##0 unlock_req |=> unlock_grant)
    else $error("unlock refused with protect high");
  wr_pulse_a: assert property (wr_strobe |=> !wr_strobe)
    else $error("write pulse too long");
  wr_hold_a: assert property ($changed(wr_data) |-> wr_strobe)
    else $error("write data moved without strobe");
  async_wait_a: assert property ((!sync_mode_sel && wait_oe && $stable(read_config_reg))[*8]
    |-> wait_out == !read_config_reg[WAIT_POL_BIT]) else $error("wait asserted in async mode");
  sync_wait_a: assert property ((sync_mode_sel && !array_data_valid && !chip_sel_n && !out_en_n && write_n
    && $stable(read_config_reg))[*8] |-> wait_out == read_config_reg[WAIT_POL_BIT]) else $error("wait not asserted");
endmodule // flash_pin_monitor

bind flash_pin_ctrl flash_pin_monitor flash_pin_monitor_i (.clk, .resetn, .chip_sel_n, .out_en_n, .write_n,
  .write_protect_n, .sync_mode_sel, .array_data_valid, .unlock_req, .block_locked_down, .read_config_reg,
  .wr_data, .wait_out, .wait_oe, .dq_oe, .addr_captured, .wr_strobe, .unlock_grant, .die_active);

//--- bench/flash_host.sv
// host memory controller model driving the flash pins
`timescale 1ns/1ps
module flash_host (
  input logic clk,
  output logic cs_n,
  output logic oe_n,
  output logic we_n,
  output logic adv_n,
  output logic bclk,
  output logic [flash_pin_pkg::ADDR_W-1:0] a,
  output logic [flash_pin_pkg::DATA_W-1:0] d,
  output logic [3:0] ram_n
);
  import flash_pin_pkg::*;
  // idle levels; the bus clock stands still between frames
  initial begin
    {cs_n, oe_n, we_n, adv_n, bclk} = 5'h1E;
    a = '0;
    d = '0;
    ram_n = 4'h0;
  end
  // ram pins float on this die, shown as noise
  always @(posedge clk) ram_n <= #1 ram_n + 4'h1;
  //////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // released lines show the inverse, never a stale value
  // idle is held so a following request cannot hide the release
  task automatic rel();
    {cs_n, oe_n, we_n, adv_n} = 4'hF;
    a = ~a;
    d = ~d;
    step(4);
  endtask
  // levels stand 4 clocks so the 2-flop sampling sees them
  task automatic wr(input logic sel, input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] wd);
    cs_n = !sel;
    a = wa;
    d = wd;
    we_n = 0;
    step(4);
    we_n = 1;
    step(4);
    rel();
  endtask
  task automatic rd(input logic sel, input logic [ADDR_W-1:0] ra);
    cs_n = !sel;
    oe_n = 0;
    a = ra;
    adv_n = 0;
    step(4);
  endtask
  task automatic adv_up();
    adv_n = 1;
    step(4);
  endtask
  task automatic bpulse(input int n);
    repeat (n) begin
      bclk = 1;
      step(4);
      bclk = 0;
      step(4);
    end
  endtask
endmodule // flash_host

//--- bench/test_flash_pin_ctrl.sv
// self-checking testbench for the flash pin control
`timescale 1ns/1ps
module test_flash_pin_ctrl;
  import flash_pin_pkg::*;
  logic clk, resetn, sync_sel, dvalid, ureq, locked, wp_n, seen_wr, seen_cap;
  // pins come from the host model, so they are nets here
  wire cs_n, oe_n, we_n, adv_n, bclk;
  logic dq_oe, wait_out, wait_oe, addr_captured;
  logic wr_strobe, unlock_grant, lockdown_on, die_active, sync_mode;
  logic [CFG_W-1:0] cfg;
  logic [DATA_W-1:0] rdat, dq_out, wr_data;
  wire [DATA_W-1:0] d;
  logic [ADDR_W-1:0] array_addr, wr_addr;
  wire [ADDR_W-1:0] a;
  wire [3:0] ram_n;
  int err_total, n_tests;
  flash_host host_i (.clk, .cs_n, .oe_n, .we_n, .adv_n, .bclk, .a, .d, .ram_n);
  flash_pin_ctrl flash_pin_ctrl_i (.clk, .resetn, .chip_sel_n(cs_n), .out_en_n(oe_n), .write_n(we_n),
    .address_valid_n(adv_n), .bus_clk(bclk), .write_protect_n(wp_n), .addr(a), .dq_in(d),
    .ram_out_en_n(ram_n[0]), .ram_write_n(ram_n[1]), .ram_upper_byte_n(ram_n[2]), .ram_lower_byte_n(ram_n[3]),
    .read_config_reg(cfg), .sync_mode_sel(sync_sel), .array_data_valid(dvalid), .array_rd_data(rdat),
    .unlock_req(ureq), .block_locked_down(locked), .dq_out, .dq_oe, .wait_out, .wait_oe, .array_addr,
    .addr_captured, .wr_addr, .wr_data, .wr_strobe, .unlock_grant, .lockdown_on, .die_active, .sync_mode);
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // sticky catchers so a one-cycle pulse is never missed
  always @(posedge clk) begin
    if (wr_strobe === 1'b1) seen_wr <= 1;
    if (addr_captured === 1'b1) seen_cap <= 1;
  end
  //////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // every protect and lock pairing, one unlock each
  task automatic t_lock();
    for (int i = 0; i < 4; i++) begin
      wp_n = i[0];
      locked = i[1];
      host_i.step(9);
      chk("lockdown_on", !i[0], lockdown_on);
      ureq = 1;
      host_i.step(1);
      chk("unlock_grant", i[0] | !i[1], unlock_grant);
      ureq = 0;
    end
    $display("t_lock done");
  endtask
  task automatic t_desel();
    seen_wr = 0;
    seen_cap = 0;
    host_i.wr(0, 23'h000111, 16'h2222);
    host_i.rd(0, 23'h000333);
    host_i.adv_up();
    chk("des_wr", 0, seen_wr);
    chk("des_cap", 0, seen_cap);
    chk("des_oe", 0, {wait_oe, dq_oe, die_active});
    host_i.rel();
    $display("t_desel done");
  endtask
  task automatic t_write();
    seen_wr = 0;
    host_i.wr(1, 23'h5A5A5A, 16'hC3C3);
    host_i.step(2);
    chk("wr_seen", 1, seen_wr);
    chk("wr_addr", 23'h5A5A5A, wr_addr);
    chk("wr_data", 16'hC3C3, wr_data);
    $display("t_write done");
  endtask
  // flow-through while valid is low, latched on its rise
  task automatic t_async();
    cfg = 16'h0400;
    host_i.rd(1, 23'h000100);
    host_i.a = 23'h000200;
    host_i.step(6);
    chk("flow_addr", 23'h000200, array_addr);
    chk("drive", 3'h7, {wait_oe, dq_oe, die_active});
    chk("dq_out", 16'hBEEF, dq_out);
    chk("async_wait", 0, wait_out);
    seen_cap = 0;
    host_i.adv_up();
    host_i.a = 23'h7FFFFF;
    host_i.step(6);
    chk("latch_cap", 1, seen_cap);
    chk("latch_addr", 23'h000200, array_addr);
    host_i.rel();
    $display("t_async done");
  endtask
  // capture on first bus clock or on the valid rise, then three burst steps
  task automatic t_sync(input logic pol);
    sync_sel = 1;
    cfg = {5'h00, pol, 10'h000};
    dvalid = 0;
    seen_cap = 0;
    rdat = pol ? 16'h8421 : 16'h1248;
    host_i.rd(1, 23'h0FFFFE);
    // one pass captures on the clock edge, the other on the valid rise
    if (!pol) begin
      host_i.bpulse(1);
      chk("clk_cap", 1, seen_cap);
    end
    host_i.adv_up();
    chk("first_cap", 1, seen_cap);
    host_i.bpulse(3);
    chk("burst_addr", 23'h100001, array_addr);
    chk("sync_mode", 1, sync_mode);
    chk("sync_dq", pol ? 16'h8421 : 16'h1248, dq_out);
    chk("wait_busy", pol, wait_out);
    dvalid = 1;
    host_i.step(3);
    chk("wait_valid", !pol, wait_out);
    host_i.rel();
    $display("t_sync done");
  endtask
  //////////////////////////////
  initial begin
    {resetn, sync_sel, dvalid, ureq, locked, wp_n} = 6'h01;
    cfg = 16'h0000;
    rdat = 16'hBEEF;
    {seen_wr, seen_cap} = 2'h0;
    err_total = 0;
    n_tests = 0;
    host_i.step(3);
    chk("rst_out", 3'h1, {sync_mode, dq_oe, lockdown_on});
    host_i.step(7);
    resetn = 1;
    host_i.step(6);
    t_lock();
    t_desel();
    t_write();
    t_async();
    t_sync(0);
    t_sync(1);
    end_sim();
  end
  // tests need about 1 us; 20 us means a hang
  initial begin
    #20us;
    err_total++;
    $display("watchdog expired");
    end_sim();
  end
endmodule // test_flash_pin_ctrl
